// [cssv_pkg.sv]
// Purpose: shared constants and carrier types for the converter start-up and fault supervisor
// Assumes: 40 MHz logic clock; analog comparators deliver single-bit flags
// Notes:   voltages are counted in 12.5 mV code steps where the logic needs them
package cssv_pkg;

  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned NUM_PHASES     = 4;

  // wishbone register map (byte addresses)
  localparam logic [3:0]  ADDR_CTRL      = 4'h0;
  localparam logic [3:0]  ADDR_STATUS    = 4'h4;
  localparam logic [3:0]  ADDR_REF       = 4'h8;
  localparam logic [3:0]  ADDR_SW_DIV    = 4'hc;

  // control register fields
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam logic [31:0] CTRL_RESET_VAL  = 32'h0000_0000;

  // switching-period divider default: 500 kHz from 40 MHz
  localparam logic [15:0] SW_DIV_RESET   = 16'h0050;

  // soft-start timing in switching cycles
  localparam logic [12:0] SS_DELAY_CYC   = 13'h0040;  // 64
  localparam logic [12:0] OFS_RAMP_CYC   = 13'h0280;  // 640
  localparam logic [12:0] HICCUP_CYC     = 13'h1000;  // 4096
  localparam logic [3:0]  OC_PERSIST_CYC = 4'h8;      // eight
  localparam int unsigned VID_OFF_WAIT   = 2;         // cycles after all-ones code

  // reference ramp: one 12.5 mV step every 32 us
  localparam int unsigned RAMP_STEP_US   = 32;
  localparam int unsigned RAMP_STEP_CYC  = (CLK_HZ / 1_000_000) * RAMP_STEP_US;

  // voltage-id code that signals no load present
  localparam logic [5:0]  VID_NO_LOAD    = 6'h3f;

  // remote-sense offset, 100 mV in 12.5 mV steps
  localparam logic [3:0]  SENSE_OFS_MAX  = 4'h8;

  // overvoltage trip level selection (analog front end picks the actual level)
  typedef enum logic [2:0] {
    OV_AUX_1V8,        // supply above 1.4 V but not valid
    OV_PRE_1V7,        // valid supply, not yet enabled
    OV_CODE_PLUS,      // code plus 200 mV
    OV_MAX_1V5_CODE    // higher of 1.5 V and code plus 200 mV
  } cssv_ov_level_type;

  // comparator flags from the analog front end
  typedef struct packed {
    logic                  supply_above_aux;   // supply above 1.4 V
    logic                  supply_valid;       // above power-on reset threshold
    logic                  thresh_enable;      // enable pin above 1.29 V
    logic                  logic_level_enable_in;
    logic                  overvoltage;        // sense above selected trip level
    logic                  below_discharge;    // sense below 0.6 V (valid) / 1.5 V
    logic                  diff_at_reference;  // differential sense at reference
    logic                  undervoltage;       // sense below 75 % of code
    logic                  avg_overcurrent;    // average current above 110 uA ref
    logic [NUM_PHASES-1:0] phase_overcurrent;  // per-phase current above ref
    logic                  prebias_reached;    // ramping reference at output level
  } cssv_flags_type;

  // phase drive towards the external drivers; oe low means driven
  typedef struct packed {
    logic [NUM_PHASES-1:0] pwm;
    logic [NUM_PHASES-1:0] pwm_oe_n;
  } cssv_phase_type;

endpackage

// [cssv_supervisor.sv]
// Purpose: start-up, power-good, overvoltage and overcurrent supervisor
// Assumes: comparator flags arrive asynchronously; pwm_run_i comes from the modulator
// Notes:   timing counts use a one-cycle switching tick from an internal divider, except the ramp step, which counts clocks
//
// What this block does
// - shutdown keeps all phase outputs high impedance
// - start soft-start when all four enables hold
// - all-ones code: wait two cycles, then shut
// - no-load code never clears overvoltage latch
// - ramp reference; hi-z until pre-bias reached
// - 64-cycle delay then 12.5mV per 32us
// - 100mV sense offset ramps out over 512
// - power-good low in shutdown, high after start
// - power-good falls only on undervoltage, disable or no-load code
// - overvoltage alone leaves power-good untouched
// - undervoltage below 75% pulls power-good low
// - auxiliary 1.8V overvoltage before supply valid
// - overvoltage trip level follows state
// - overvoltage forces phases low until discharged
// - low phases go hi-z at reference; recur
// - crowbar output fires with forced-low phases
// - overvoltage latch cleared only by enable cycling
// - average overcurrent trips immediately
// - per-phase overcurrent for eight cycles trips
// - overcurrent: hi-z for 4096, then retry
`timescale 1ns/1ps
`default_nettype none

module cssv_supervisor
  import cssv_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [3:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // analog front end
  input  wire cssv_flags_type        flags_i,
  input  wire logic [5:0]            voltage_id_code_i,
  input  wire logic [NUM_PHASES-1:0] pwm_run_i,
  output cssv_ov_level_type          ov_level_o,
  output logic      [5:0]            ref_code_o,
  output logic      [3:0]            sense_offset_o,
  // pins
  output cssv_phase_type             phase_o,
  output logic                       output_ok_flag_o,
  output logic                       output_ok_flag_oe_n_o,
  output logic                       crowbar_drive_out_o
);

  typedef enum logic [2:0] {
    ST_OFF,
    ST_SS_DELAY,
    ST_SS_RAMP,
    ST_RUN,
    ST_OV_TRIP,
    ST_OC_WAIT
  } cssv_state_type;

  function automatic logic [12:0] count_up(input logic [12:0] c, input logic hit);
    count_up = hit ? c + 13'h0001 : c;
  endfunction

  // two-stage synchroniser for every comparator flag
  cssv_flags_type flags_meta_q;
  cssv_flags_type flags_q;
  logic [5:0]     vid_meta_q;
  logic [5:0]     vid_q;

  always_ff @(posedge clk_i) begin
    flags_meta_q <= flags_i;
    flags_q      <= flags_meta_q;
    vid_meta_q   <= voltage_id_code_i;
    vid_q        <= vid_meta_q;
  end

  // registers
  logic [31:0]    ctrl_q;
  logic [15:0]    sw_div_q;
  logic [31:0]    rd_data;
  logic           wb_req;
  logic           wb_wr;
  logic           ack_q;
  logic [31:0]    dat_q;

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
  // the write lands on the edge where the master samples ack high
  assign wb_wr  = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q   <= CTRL_RESET_VAL;
      sw_div_q <= SW_DIV_RESET;
      ack_q    <= 1'b0;
      dat_q    <= 32'h0;
    end else begin
      ack_q <= wb_req;
      dat_q <= wb_req ? rd_data : 32'h0;
      if (wb_wr && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
        ctrl_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_wr && wb_adr_i == ADDR_SW_DIV) begin
        if (wb_sel_i[0]) begin
          sw_div_q[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          sw_div_q[15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // switching-period tick
  logic [15:0] div_q;
  logic        sw_tick;

  // a divider of zero wraps to the longest period rather than stalling the tick
  assign sw_tick = (div_q == 16'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= 16'h0;
    end else begin
      div_q <= sw_tick ? sw_div_q - 16'h0001 : div_q - 16'h0001;
    end
  end

  // enable conditions
  logic enabled;
  logic no_load_code;

  assign no_load_code = (vid_q == VID_NO_LOAD);
  assign enabled = flags_q.supply_valid & flags_q.thresh_enable &
                   flags_q.logic_level_enable_in & ctrl_q[CTRL_ENABLE_BIT];

  // state
  cssv_state_type state_q;
  logic [12:0]    cyc_q;
  logic [1:0]     vid_wait_q;
  logic [3:0]     oc_cnt_q [NUM_PHASES];
  logic           ov_latch_q;
  logic           prev_en_q;
  logic           oc_hold;
  logic           ov_event;
  logic           oc_event;
  logic [11:0]    ramp_q;
  logic [5:0]     ref_q;
  logic [3:0]     sofs_q;
  logic           drive_low_q;
  logic           output_ok_flag_q;
  logic           phase_oc_trip;

  assign oc_hold  = (state_q == ST_OC_WAIT);
  assign ov_event = flags_q.overvoltage & (flags_q.supply_valid | flags_q.supply_above_aux);

  // read decode needs the sequencer state, so it sits below its declarations
  logic        sel_ctrl;
  logic        sel_status;
  logic        sel_ref;
  logic        sel_sw_div;
  logic [31:0] status_word;
  logic [31:0] ref_word;

  assign sel_ctrl    = (wb_adr_i == ADDR_CTRL);
  assign sel_status  = (wb_adr_i == ADDR_STATUS);
  assign sel_ref     = (wb_adr_i == ADDR_REF);
  assign sel_sw_div  = (wb_adr_i == ADDR_SW_DIV);
  // bit 4 shows the power-good pin as released, not its always-low data line
  assign status_word = {25'h0, ov_latch_q, oc_hold, output_ok_flag_oe_n_o,
                        crowbar_drive_out_o, 3'(state_q)};
  assign ref_word    = {22'h0, sense_offset_o, ref_code_o};
  assign rd_data     = sel_ctrl   ? ctrl_q :
                       sel_status ? status_word :
                       sel_ref    ? ref_word :
                       sel_sw_div ? {16'h0, sw_div_q} :
                       32'h0;

  always_comb begin
    phase_oc_trip = 1'b0;
    for (int i = 0; i < NUM_PHASES; i++) begin
      if (oc_cnt_q[i] == OC_PERSIST_CYC) begin
        phase_oc_trip = 1'b1;
      end
    end
  end

  assign oc_event = flags_q.avg_overcurrent | phase_oc_trip;

  // per-phase persistence counters
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NUM_PHASES; i++) begin
      if (rst_i || !flags_q.phase_overcurrent[i]) begin
        oc_cnt_q[i] <= 4'h0;
      end else if (sw_tick && oc_cnt_q[i] != OC_PERSIST_CYC) begin
        oc_cnt_q[i] <= oc_cnt_q[i] + 4'h1;
      end
    end
  end

  // main sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q    <= ST_OFF;
      cyc_q      <= 13'h0;
      vid_wait_q <= 2'h0;
      ov_latch_q <= 1'b0;
      prev_en_q  <= 1'b0;
      ramp_q     <= 12'h0;
      ref_q      <= 6'h0;
      sofs_q     <= 4'h0;
    end else begin
      prev_en_q <= enabled;
      if (!enabled) begin
        ov_latch_q <= 1'b0;
      end
      if (ov_event) begin
        ov_latch_q <= 1'b1;
      end
      // no-load code counts two switching cycles before shutting down
      if (no_load_code && state_q != ST_OFF && state_q != ST_OV_TRIP) begin
        if (sw_tick) begin
          vid_wait_q <= vid_wait_q + 2'h1;
        end
      end else begin
        vid_wait_q <= 2'h0;
      end
      case (state_q)
        ST_OFF: begin
          ref_q  <= 6'h0;
          sofs_q <= 4'h0;
          if (ov_latch_q || ov_event) begin
            state_q <= ST_OV_TRIP;
          end else if (enabled && !no_load_code) begin
            state_q <= ST_SS_DELAY;
            cyc_q   <= 13'h0;
            sofs_q  <= SENSE_OFS_MAX;
          end
        end
        ST_SS_DELAY, ST_SS_RAMP, ST_RUN: begin
          if (ov_event) begin
            state_q <= ST_OV_TRIP;
          end else if (!enabled || vid_wait_q == 2'(VID_OFF_WAIT)) begin
            state_q <= ST_OFF;
          end else if (oc_event) begin
            state_q <= ST_OC_WAIT;
            cyc_q   <= 13'h0;
          end else if (state_q == ST_SS_DELAY) begin
            cyc_q <= count_up(cyc_q, sw_tick);
            if (cyc_q == SS_DELAY_CYC) begin
              state_q <= ST_SS_RAMP;
              cyc_q   <= 13'h0;
              ramp_q  <= 12'h0;
            end
          end else if (state_q == ST_SS_RAMP) begin
            cyc_q <= count_up(cyc_q, sw_tick);
            if (sw_tick && cyc_q < OFS_RAMP_CYC &&
                cyc_q[5:0] == 6'h3f && sofs_q != 4'h0) begin
              sofs_q <= sofs_q - 4'h1;
            end
            // the step is timed in clocks, so 32 us holds whatever the switching rate
            if (ramp_q == 12'(RAMP_STEP_CYC - 1)) begin
              ramp_q <= 12'h0;
              if (ref_q != vid_q) begin
                ref_q <= ref_q + 6'h01;
              end
            end else begin
              ramp_q <= ramp_q + 12'h001;
            end
            if (ref_q == vid_q && sofs_q == 4'h0) begin
              state_q <= ST_RUN;
            end
          end else begin
            ref_q <= vid_q;
          end
        end
        ST_OV_TRIP: begin
          // only a falling enable leaves; code changes are ignored here
          if (!enabled && prev_en_q) begin
            state_q <= ST_OFF;
          end
        end
        ST_OC_WAIT: begin
          ref_q  <= 6'h0;
          sofs_q <= 4'h0;
          cyc_q  <= count_up(cyc_q, sw_tick);
          if (ov_event) begin
            state_q <= ST_OV_TRIP;
          end else if (cyc_q == HICCUP_CYC) begin
            state_q <= ST_OFF;
          end
        end
        default: state_q <= ST_OFF;
      endcase
    end
  end

  // overvoltage discharge: low until discharged, hi-z at reference, low on recurrence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_low_q <= 1'b0;
    end else if (ov_event) begin
      drive_low_q <= 1'b1;
    end else if (flags_q.below_discharge || flags_q.diff_at_reference) begin
      drive_low_q <= 1'b0;
    end
  end

  // power-good: undervoltage, disable or no-load code only
  // a hiccup retry keeps it released; the collapsing output trips undervoltage instead
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      output_ok_flag_q <= 1'b0;
    end else if (!enabled || no_load_code) begin
      output_ok_flag_q <= 1'b0;
    end else if (flags_q.undervoltage) begin
      output_ok_flag_q <= 1'b0;
    end else if (state_q == ST_RUN) begin
      output_ok_flag_q <= 1'b1;
    end
  end

  // outputs, all from flip-flops
  logic driving;
  assign driving = (state_q == ST_SS_RAMP || state_q == ST_RUN) &&
                   (flags_q.prebias_reached || state_q == ST_RUN);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_o               <= '{pwm: '0, pwm_oe_n: '1};
      output_ok_flag_o      <= 1'b0;
      output_ok_flag_oe_n_o <= 1'b0;
      crowbar_drive_out_o   <= 1'b0;
      ov_level_o            <= OV_PRE_1V7;
      ref_code_o            <= 6'h0;
      sense_offset_o        <= 4'h0;
    end else begin
      if (drive_low_q || ov_event) begin
        phase_o <= '{pwm: '0, pwm_oe_n: '0};
      end else if (driving && !oc_event) begin
        phase_o <= '{pwm: pwm_run_i, pwm_oe_n: '0};
      end else begin
        phase_o <= '{pwm: '0, pwm_oe_n: '1};
      end
      crowbar_drive_out_o   <= drive_low_q | ov_event;
      output_ok_flag_o      <= 1'b0;
      output_ok_flag_oe_n_o <= output_ok_flag_q;
      if (!flags_q.supply_valid) begin
        ov_level_o <= OV_AUX_1V8;
      end else if (state_q == ST_OFF) begin
        ov_level_o <= ov_latch_q ? OV_CODE_PLUS : OV_PRE_1V7;
      end else if (state_q == ST_SS_DELAY || state_q == ST_SS_RAMP) begin
        ov_level_o <= OV_MAX_1V5_CODE;
      end else begin
        ov_level_o <= OV_CODE_PLUS;
      end
      ref_code_o     <= ref_q;
      sense_offset_o <= sofs_q;
    end
  end

endmodule

`default_nettype wire

// [cssv_supervisor_sva.sv]
// Purpose: pin-level checks for the supervisor
// Assumes: flags pass two sync flops before use
// Notes: six-cycle windows cover sync and output flops
`timescale 1ns/1ps
`default_nettype none
module cssv_supervisor_sva
  import cssv_pkg::*;
(
  // clock and reset
  input wire logic           clk_i,
  input wire logic           rst_i,
  // bus
  input wire logic           wb_cyc_i,
  input wire logic           wb_stb_i,
  input wire logic           wb_ack_o,
  // front end
  input wire cssv_flags_type flags_i,
  input wire logic [5:0]     voltage_id_code_i,
  // pins
  input wire cssv_phase_type phase_o,
  input wire logic           output_ok_flag_o,
  input wire logic           output_ok_flag_oe_n_o,
  input wire logic           crowbar_drive_out_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // saturating count of cycles on the no-load code
  logic [9:0] idle_q;
  logic [9:0] idle_d;
  assign idle_d = (voltage_id_code_i != VID_NO_LOAD) ? 10'h000 : idle_q + {9'h000, ~idle_q[9]};
  always_ff @(posedge clk_i) begin
    idle_q <= rst_i ? 10'h000 : idle_d;
  end
  sequence s_on;
    (flags_i.supply_valid && flags_i.thresh_enable && flags_i.logic_level_enable_in &&
     voltage_id_code_i != VID_NO_LOAD && !flags_i.undervoltage)[*6];
  endsequence
  sequence s_off;
    (!flags_i.thresh_enable && !crowbar_drive_out_o)[*6];
  endsequence
  chk_output_ok_flag_hold: assert property
    (s_on ##0 output_ok_flag_oe_n_o |=> output_ok_flag_oe_n_o) else $error("output_ok_flag fell");
  chk_shut_output_ok_flag: assert property
    (s_off |-> !output_ok_flag_oe_n_o) else $error("output_ok_flag released in shutdown");
  chk_shut_hiz: assert property
    (s_off |-> phase_o.pwm_oe_n == '1) else $error("phase driven in shutdown");
  chk_od_low: assert property
    (output_ok_flag_o == 1'b0) else $error("output_ok_flag data not low");
  chk_uv_pull: assert property
    (flags_i.undervoltage [*6] |-> !output_ok_flag_oe_n_o) else $error("uv ignored");
  chk_ov_force: assert property
    ($rose(crowbar_drive_out_o) |-> phase_o.pwm == '0 && phase_o.pwm_oe_n == '0)
    else $error("crowbar without low phases");
  chk_ov_fire: assert property
    ((flags_i.supply_valid && flags_i.overvoltage)[*6] |-> crowbar_drive_out_o)
    else $error("ov ignored");
  chk_oc_hiz: assert property
    ((flags_i.avg_overcurrent && !crowbar_drive_out_o)[*6] |-> phase_o.pwm_oe_n == '1)
    else $error("oc ignored");
  chk_noload_hiz: assert property
    (idle_q[9] && !crowbar_drive_out_o |-> phase_o.pwm_oe_n == '1) else $error("no-load ignored");
  chk_ack_pulse: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) else $error("bad ack");
endmodule
bind cssv_supervisor cssv_supervisor_sva cssv_supervisor_sva_inst (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .flags_i, .voltage_id_code_i,
  .phase_o, .output_ok_flag_o, .output_ok_flag_oe_n_o, .crowbar_drive_out_o
);
`default_nettype wire

// [cssv_driver_model.sv]
// Purpose: gate drivers and pre-bias comparator beside the supervisor
// Assumes: driver sees a released pwm pin as mid-level
// Notes: no gate delays; the supervisor syncs the flag anyway
`timescale 1ns/1ps
`default_nettype none
module cssv_driver_model
  import cssv_pkg::*;
(
  // phase drive and levels
  input  wire cssv_phase_type        phase_i,
  input  wire logic [5:0]            ref_code_i,
  input  wire logic [5:0]            prebias_code_i,
  // gates and flag
  output logic      [NUM_PHASES-1:0] gate_lo_o,
  output logic                       prebias_reached_o
);
  // a floating pwm input turns both switches off
  assign gate_lo_o = ~phase_i.pwm_oe_n & ~phase_i.pwm;
  assign prebias_reached_o = ref_code_i >= prebias_code_i;
endmodule
`default_nettype wire

// [test_cssv_supervisor.sv]
// Purpose: self-checking bench for the supervisor
// Assumes: switching tick cut to two clocks
// Notes: flags driven directly, pre-bias from the model
`timescale 1ns/1ps
`default_nettype none
module test_cssv_supervisor
  import cssv_pkg::*;
;
  logic clk_i, rst_i, cyc, stb, we, ack, ok_n, okd, crow, pbr;
  logic [3:0] adr, ofs, run, glo;
  logic [31:0] wdat, rdat, rd, rnd;
  logic [5:0] voltage_id_code, refc, pre;
  cssv_flags_type fl, flw;
  cssv_ov_level_type ovl;
  cssv_phase_type ph;
  int err_total, checked, n;
  assign flw = {fl[$bits(cssv_flags_type)-1:1], pbr};
  cssv_supervisor cssv_supervisor_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .flags_i(flw), .voltage_id_code_i(voltage_id_code), .pwm_run_i(run), .ov_level_o(ovl),
    .ref_code_o(refc), .sense_offset_o(ofs), .phase_o(ph), .output_ok_flag_o(okd),
    .output_ok_flag_oe_n_o(ok_n), .crowbar_drive_out_o(crow));
  cssv_driver_model cssv_driver_model_inst (.phase_i(ph), .ref_code_i(refc),
    .prebias_code_i(pre), .gate_lo_o(glo), .prebias_reached_o(pbr));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] probe(input int w);
    case (w)
      0: return {4'h0, ph.pwm_oe_n};
      1: return {7'h0, ok_n};
      default: return {2'h0, refc};
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic await(input int w, input logic [7:0] e, input int lim);
    n = 0;
    while (probe(w) !== e && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    chk("ack", ack, 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic cyc_n(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    cyc_n(60000);
    err_total++;
    report_and_stop();
  end
  initial begin
    {rst_i, cyc, stb, we, adr, wdat, run, fl} = '0;
    rst_i = 1'b1;
    rnd = 32'h6439fd35;
    pre = 6'h02;
    voltage_id_code = 6'h02 + {4'h0, rnd[1:0]};
    {err_total, checked} = '0;
    cyc_n(12);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("oe_n", ph.pwm_oe_n, 4'hf);
    chk("pg_oe_n", ok_n, 1'b0);
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", rd, CTRL_RESET_VAL);
    wb(1'b0, ADDR_SW_DIV, 32'h0);
    chk("sw_div", rd, {16'h0, SW_DIV_RESET});
    wb(1'b1, 4'h2, 32'hffffffff);
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped", rd, 32'h0);
    wb(1'b1, ADDR_SW_DIV, 32'h2);
    wb(1'b0, ADDR_SW_DIV, 32'h0);
    chk("sw_div", rd, 32'h2);
    rnd = lfsr(rnd);
    run <= rnd[3:0];
    {fl.supply_valid, fl.thresh_enable, fl.logic_level_enable_in} <= 3'h7;
    wb(1'b1, ADDR_CTRL, 32'h1);
    cyc_n(3);
    chk("offset", ofs, SENSE_OFS_MAX);
    chk("ovl_ss", ovl, OV_MAX_1V5_CODE);
    await(2, 8'h01, 2000);
    chk("prebias_hiz", ph.pwm_oe_n, 4'hf);
    await(2, 8'h02, 2000);
    chk("ramp_step", n, RAMP_STEP_CYC);
    await(1, 8'h01, 9000);
    chk("ref", refc, voltage_id_code);
    chk("offset", ofs, 4'h0);
    chk("ovl", ovl, OV_CODE_PLUS);
    chk("pwm", ph.pwm, run);
    fl.undervoltage <= 1'b1;
    await(1, 8'h00, 20);
    chk("pg_uv", ok_n, 1'b0);
    chk("pg_data", okd, 1'b0);
    fl.undervoltage <= 1'b0;
    await(1, 8'h01, 20);
    chk("pg_back", ok_n, 1'b1);
    fl.overvoltage <= 1'b1;
    cyc_n(6);
    chk("ov_low", glo, 4'hf);
    chk("crowbar", crow, 1'b1);
    chk("pg_ov", ok_n, 1'b1);
    {fl.overvoltage, fl.below_discharge, fl.diff_at_reference} <= 3'h3;
    await(0, 8'h0f, 20);
    chk("ov_hiz", ph.pwm_oe_n, 4'hf);
    chk("ovl_trip", ovl, OV_CODE_PLUS);
    {fl.overvoltage, fl.diff_at_reference} <= 2'h2;
    cyc_n(6);
    chk("ov_again", glo, 4'hf);
    {fl.overvoltage, fl.diff_at_reference} <= 2'h1;
    voltage_id_code <= VID_NO_LOAD;
    cyc_n(20);
    voltage_id_code <= 6'h03;
    cyc_n(5000);
    chk("latched", ph.pwm_oe_n, 4'hf);
    fl.logic_level_enable_in <= 1'b0;
    await(1, 8'h00, 20);
    chk("pg_off", ok_n, 1'b0);
    cyc_n(6);
    {fl.logic_level_enable_in, fl.below_discharge, fl.diff_at_reference} <= 3'h4;
    await(0, 8'h00, 9000);
    chk("restart", ph.pwm_oe_n, 4'h0);
    fl.avg_overcurrent <= 1'b1;
    await(0, 8'h0f, 20);
    chk("oc_hiz", ph.pwm_oe_n, 4'hf);
    fl.avg_overcurrent <= 1'b0;
    await(0, 8'h00, 20000);
    chk("hiccup", n >= 2 * HICCUP_CYC && n < 20000, 1'b1);
    voltage_id_code <= VID_NO_LOAD;
    await(0, 8'h0f, 40);
    chk("noload", ph.pwm_oe_n, 4'hf);
    chk("pg_noload", ok_n, 1'b0);
    voltage_id_code <= 6'h02;
    await(0, 8'h00, 9000);
    chk("noload_end", ph.pwm_oe_n, 4'h0);
    rnd = lfsr(rnd);
    fl.phase_overcurrent <= 4'h1 << rnd[1:0];
    cyc_n(12);
    fl.phase_overcurrent <= 4'h0;
    cyc_n(6);
    chk("oc_short", ph.pwm_oe_n, 4'h0);
    fl.phase_overcurrent <= 4'h1 << rnd[1:0];
    await(0, 8'h0f, 40);
    chk("oc_phase", ph.pwm_oe_n, 4'hf);
    report_and_stop();
  end
endmodule
`default_nettype wire
